// ---- hw/cae_alert_top.sv ----
`default_nettype none
module cae_alert_top (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_STB,
    input wire logic [15:0] WR_DATA,
    output logic [15:0] RD_DATA,
    input wire logic [5:0] LIMIT_COND,
    input wire logic DETECT_FAIL,
    input wire logic DETECTION,
    input wire logic SUSPENDED,
    input wire logic PRECHARGE,
    input wire logic BULK_PHASE_STATE,
    output logic SMB_ALERT_OUT,
    output logic SMB_ALERT_OE_N
);
    cae_pkg::cae_wr_t wr;
    logic [15:0] limit_en_ff;
    logic [15:0] nxt_limit_en_ff;
    logic [12:0] state_en_ff;
    logic [12:0] nxt_state_en_ff;
    logic [4:0] state_prev_ff;
    logic [4:0] nxt_state_prev_ff;
    logic [15:0] rd_ff;
    logic [15:0] nxt_rd_ff;
    logic alert_oe_n_ff;
    logic nxt_alert_oe_n_ff;
    logic [4:0] state_now;
    logic [4:0] state_entry;
    logic [15:0] limit_set;
    logic [12:0] state_set;
    logic [15:0] limit_flags;
    logic [12:0] state_flags;
    logic pending;

    assign wr = '{stb: WR_STB, code: CMD_CODE, data: WR_DATA};
    assign state_now = {DETECT_FAIL, DETECTION, SUSPENDED, PRECHARGE,
                        BULK_PHASE_STATE};

    // Enable registers
    always_comb begin
        nxt_limit_en_ff = limit_en_ff;
        nxt_state_en_ff = state_en_ff;
        if (wr.stb && wr.code == cae_pkg::CODE_LIMIT_EN) begin
            nxt_limit_en_ff = wr.data;
        end
        if (wr.stb && wr.code == cae_pkg::CODE_STATE_EN) begin
            nxt_state_en_ff = wr.data[12:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            limit_en_ff <= cae_pkg::LIMIT_EN_RST;
            state_en_ff <= cae_pkg::STATE_EN_RST;
        end else begin
            limit_en_ff <= nxt_limit_en_ff;
            state_en_ff <= nxt_state_en_ff;
        end
    end

    // Limit conditions are levels; latch while the condition holds
    always_comb begin
        limit_set = '0;
        limit_set[5:0] = LIMIT_COND & limit_en_ff[5:0];
        // Bits 3..0 cover die, resistance, thermistor
        // Thermistor high is cold, low is hot
    end

    // Charger state events are entries, taken on the rising level
    always_comb begin
        nxt_state_prev_ff = state_now;
        state_entry = state_now & ~state_prev_ff;
        state_set = '0;
        state_set[cae_pkg::BIT_DETECT_FAILED] = state_entry[4]
            & state_en_ff[cae_pkg::BIT_DETECT_FAILED];
        state_set[cae_pkg::BIT_DETECTION_ENTRY] = state_entry[3]
            & state_en_ff[cae_pkg::BIT_DETECTION_ENTRY];
        state_set[cae_pkg::BIT_SUSPENDED] = state_entry[2]
            & state_en_ff[cae_pkg::BIT_SUSPENDED];
        state_set[cae_pkg::BIT_PRECHARGE] = state_entry[1]
            & state_en_ff[cae_pkg::BIT_PRECHARGE];
        state_set[cae_pkg::BIT_BULK_PHASE] = state_entry[0]
            & state_en_ff[cae_pkg::BIT_BULK_PHASE];
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state_prev_ff <= 5'h00;
        end else begin
            state_prev_ff <= nxt_state_prev_ff;
        end
    end

    // Sticky flags, cleared by writing 0 to the flag register
    cae_flag_bank #(.W(cae_pkg::LIMIT_W)) u_limit_flags (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .set_req(limit_set),
        .clr_we(wr.stb && wr.code == cae_pkg::CODE_LIMIT_FLAGS),
        .clr_data(wr.data),
        .flags(limit_flags)
    );

    cae_flag_bank #(.W(cae_pkg::STATE_W)) u_state_flags (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .set_req(state_set),
        .clr_we(wr.stb && wr.code == cae_pkg::CODE_STATE_FLAGS),
        .clr_data(wr.data[12:0]),
        .flags(state_flags)
    );

    // Read data and alert line
    always_comb begin
        pending = |(limit_flags & limit_en_ff)
            || |(state_flags & state_en_ff);
        nxt_alert_oe_n_ff = !pending;
        case (CMD_CODE)
            cae_pkg::CODE_LIMIT_EN: nxt_rd_ff = limit_en_ff;
            cae_pkg::CODE_STATE_EN: nxt_rd_ff = {3'h0, state_en_ff};
            cae_pkg::CODE_LIMIT_FLAGS: nxt_rd_ff = limit_flags;
            cae_pkg::CODE_STATE_FLAGS: nxt_rd_ff = {3'h0, state_flags};
            default: nxt_rd_ff = 16'h0000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rd_ff <= 16'h0000;
            alert_oe_n_ff <= 1'b1;
        end else begin
            rd_ff <= nxt_rd_ff;
            alert_oe_n_ff <= nxt_alert_oe_n_ff;
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            SMB_ALERT_OUT <= 1'b0;
        end else begin
            SMB_ALERT_OUT <= 1'b0;
        end
    end

    assign RD_DATA = rd_ff;
    assign SMB_ALERT_OE_N = alert_oe_n_ff;

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_limit_write;
        WR_STB && CMD_CODE == cae_pkg::CODE_LIMIT_EN;
    endsequence

    sequence s_detect_entry;
        !DETECTION ##1 DETECTION
            && state_en_ff[cae_pkg::BIT_DETECTION_ENTRY];
    endsequence

    sequence s_precharge_entry;
        !PRECHARGE ##1 PRECHARGE && state_en_ff[cae_pkg::BIT_PRECHARGE];
    endsequence

    a_iin_over_latch: assert property (
        LIMIT_COND[5] && limit_en_ff[5] |=> limit_flags[5]
            ##1 (!SMB_ALERT_OE_N || !$past(limit_en_ff[5])))
        else $error("input current flag not latched");

    a_ibat_under_latch: assert property (
        LIMIT_COND[4] && limit_en_ff[4] |=> limit_flags[4])
        else $error("battery current flag not latched");

    a_die_gated_off: assert property (
        !limit_flags[3] && !(LIMIT_COND[3] && limit_en_ff[3])
            |=> !limit_flags[3])
        else $error("die flag set without enabled cause");

    a_bsr_over_latch: assert property (
        LIMIT_COND[2] && limit_en_ff[2] |=> limit_flags[2])
        else $error("resistance flag not latched");

    a_ntc_over_latch: assert property (
        LIMIT_COND[1] && limit_en_ff[1] |=> limit_flags[1])
        else $error("thermistor high flag not latched");

    a_ntc_under_latch: assert property (
        LIMIT_COND[0] && limit_en_ff[0] |=> limit_flags[0])
        else $error("thermistor low flag not latched");

    a_state_en_write: assert property (
        WR_STB && CMD_CODE == cae_pkg::CODE_STATE_EN
            |=> state_en_ff == $past(WR_DATA[12:0]))
        else $error("state enable write lost");

    a_fail_latch: assert property (
        $rose(DETECT_FAIL) && state_en_ff[cae_pkg::BIT_DETECT_FAILED]
            |=> state_flags[cae_pkg::BIT_DETECT_FAILED])
        else $error("detect failed flag not latched");

    a_detect_entry: assert property (
        s_detect_entry |=> state_flags[cae_pkg::BIT_DETECTION_ENTRY]
            ##1 (!SMB_ALERT_OE_N
            || !$past(state_en_ff[cae_pkg::BIT_DETECTION_ENTRY])))
        else $error("detection entry not flagged");

    a_suspend_latch: assert property (
        $rose(SUSPENDED) && state_en_ff[cae_pkg::BIT_SUSPENDED]
            |=> state_flags[cae_pkg::BIT_SUSPENDED])
        else $error("suspend flag not latched");

    a_precharge_entry: assert property (
        s_precharge_entry |=> state_flags[cae_pkg::BIT_PRECHARGE])
        else $error("precharge entry not flagged");

    a_bulk_entry: assert property (
        $rose(BULK_PHASE_STATE) && state_en_ff[cae_pkg::BIT_BULK_PHASE]
            |=> state_flags[cae_pkg::BIT_BULK_PHASE])
        else $error("bulk phase entry not flagged");

    a_limit_en_write: assert property (
        s_limit_write |=> limit_en_ff == $past(WR_DATA)
            ##1 (RD_DATA == $past(limit_en_ff)
            || $past(CMD_CODE) != cae_pkg::CODE_LIMIT_EN))
        else $error("limit enable write lost");

    a_flag_sticky: assert property (
        limit_flags[5] && !(WR_STB && CMD_CODE == cae_pkg::CODE_LIMIT_FLAGS)
            |=> limit_flags[5])
        else $error("flag dropped without clear");

    a_alert_follow: assert property (
        pending |=> !SMB_ALERT_OE_N)
        else $error("alert not driven while pending");

    a_alert_release: assert property (
        !pending |=> SMB_ALERT_OE_N && !SMB_ALERT_OUT)
        else $error("alert not released");
endmodule
`default_nettype wire

// ---- shared/cae_pkg.sv ----
`default_nettype none
package cae_pkg;
    localparam int CMD_W = 8;
    localparam int DATA_W = 16;
    localparam int LIMIT_W = 16;
    localparam int STATE_W = 13;
    localparam int NUM_LIMIT_SRC = 6;
    localparam int NUM_STATE_SRC = 5;

    // Command codes
    localparam logic [7:0] CODE_LIMIT_EN = 8'h0d;
    localparam logic [7:0] CODE_STATE_EN = 8'h0e;
    localparam logic [7:0] CODE_LIMIT_FLAGS = 8'h40;
    localparam logic [7:0] CODE_STATE_FLAGS = 8'h41;

    // Reset values
    localparam logic [15:0] LIMIT_EN_RST = 16'h0000;
    localparam logic [12:0] STATE_EN_RST = 13'h0000;

    // Limit alert bit positions
    localparam int BIT_INPUT_CURRENT_OVER = 5;
    localparam int BIT_BATTERY_CURRENT_UNDER = 4;
    localparam int BIT_DIE_OVERHEAT = 3;
    localparam int BIT_SERIES_RESISTANCE_OVER = 2;
    localparam int BIT_NTC_READING_OVER = 1;
    localparam int BIT_NTC_READING_UNDER = 0;

    // Charger state alert bit positions
    localparam int BIT_DETECT_FAILED = 12;
    localparam int BIT_DETECTION_ENTRY = 11;
    localparam int BIT_SUSPENDED = 8;
    localparam int BIT_PRECHARGE = 7;
    localparam int BIT_BULK_PHASE = 6;

    typedef struct packed {
        logic stb;
        logic [7:0] code;
        logic [15:0] data;
    } cae_wr_t;
endpackage
`default_nettype wire

// ---- hw/cae_flag_bank.sv ----
`default_nettype none
module cae_flag_bank #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] set_req,
    input wire logic clr_we,
    input wire logic [W-1:0] clr_data,
    output logic [W-1:0] flags
);
    logic [W-1:0] flag_ff;
    logic [W-1:0] nxt_flag_ff;

    // Writing 0 clears a bit; a set in the same cycle wins
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_comb begin
            nxt_flag_ff[i] = flag_ff[i];
            if (clr_we && !clr_data[i]) begin
                nxt_flag_ff[i] = 1'b0;
            end
            if (set_req[i]) begin
                nxt_flag_ff[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag_ff;
        end
    end

    assign flags = flag_ff;
endmodule
`default_nettype wire

// ---- sim/cae_host_model.sv ----
`default_nettype none
module cae_host_model (
    input wire logic alert_out,
    input wire logic alert_oe_n,
    output logic alert_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up holds the line high while released
    assign alert_line = alert_oe_n ? 1'b1 : alert_out;
endmodule
`default_nettype wire

// ---- sim/charger_alert_enable_logic_test.sv ----
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
            err_count++; \
        end \
    end
module charger_alert_enable_logic_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    cae_pkg::cae_wr_t wr = '0;
    logic [15:0] rd_data;
    logic [5:0] limit_cond = 6'h00;
    logic [4:0] st = 5'h00;
    logic alert_out;
    logic alert_oe_n;
    logic alert_line;
    logic [15:0] rv;
    int err_count = 0;
    int comparisons = 0;
    int sbit[5] = '{cae_pkg::BIT_DETECT_FAILED,
                    cae_pkg::BIT_DETECTION_ENTRY, cae_pkg::BIT_SUSPENDED,
                    cae_pkg::BIT_PRECHARGE, cae_pkg::BIT_BULK_PHASE};

    always #50 core_clk = ~core_clk;

    cae_alert_top i_cae_alert_top (
        .CORE_CLK(core_clk),
        .NRST(nrst),
        .CMD_CODE(wr.code),
        .WR_STB(wr.stb),
        .WR_DATA(wr.data),
        .RD_DATA(rd_data),
        .LIMIT_COND(limit_cond),
        .DETECT_FAIL(st[4]),
        .DETECTION(st[3]),
        .SUSPENDED(st[2]),
        .PRECHARGE(st[1]),
        .BULK_PHASE_STATE(st[0]),
        .SMB_ALERT_OUT(alert_out),
        .SMB_ALERT_OE_N(alert_oe_n)
    );

    cae_host_model i_cae_host_model (
        .alert_out(alert_out),
        .alert_oe_n(alert_oe_n),
        .alert_line(alert_line)
    );

    task automatic close_out();
        $display("Errors %0d in %0d comparisons", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
        @(negedge core_clk);
        wr = '{stb: 1'b1, code: c, data: d};
        @(negedge core_clk);
        wr.stb = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] c, output logic [15:0] d);
        @(negedge core_clk);
        wr.code = c;
        @(negedge core_clk);
        d = rd_data;
    endtask

    task automatic wait_line(input logic exp);
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            if (alert_line === exp) begin
                comparisons++;
                return;
            end
        end
        $display("CHECK FAILED alert_line exp %h got %h", exp, alert_line);
        err_count++;
        close_out();
    endtask

    initial begin
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        `CHK("line idle", 1'b1, alert_line)
        rd_reg(cae_pkg::CODE_LIMIT_EN, rv);
        `CHK("limit en rst", cae_pkg::LIMIT_EN_RST, rv)
        rd_reg(cae_pkg::CODE_STATE_EN, rv);
        `CHK("state en rst", 16'h0000, rv)
        wr_reg(cae_pkg::CODE_LIMIT_EN, 16'hffff);
        rd_reg(cae_pkg::CODE_LIMIT_EN, rv);
        `CHK("limit en rw", 16'hffff, rv)
        wr_reg(cae_pkg::CODE_STATE_EN, 16'hffff);
        rd_reg(cae_pkg::CODE_STATE_EN, rv);
        `CHK("state en rw", 16'h1fff, rv)
        wr_reg(8'h55, 16'hffff);
        rd_reg(8'h55, rv);
        `CHK("unmapped", 16'h0000, rv)
        wr_reg(cae_pkg::CODE_LIMIT_EN, 16'h0000);
        wr_reg(cae_pkg::CODE_STATE_EN, 16'h0000);
        // Each limit source: masked first, then enabled and latched
        for (int i = 0; i < 6; i++) begin
            limit_cond = 6'h01 << i;
            repeat (3) @(negedge core_clk);
            rd_reg(cae_pkg::CODE_LIMIT_FLAGS, rv);
            `CHK("masked lim", 16'h0000, rv)
            `CHK("masked line", 1'b1, alert_line)
            wr_reg(cae_pkg::CODE_LIMIT_EN, 16'h0001 << i);
            @(negedge core_clk);
            limit_cond = 6'h00;
            wait_line(1'b0);
            repeat (3) @(negedge core_clk);
            rd_reg(cae_pkg::CODE_LIMIT_FLAGS, rv);
            `CHK("lim flag", 16'h0001 << i, rv)
            wr_reg(cae_pkg::CODE_LIMIT_FLAGS, 16'h0000);
            wait_line(1'b1);
            rd_reg(cae_pkg::CODE_LIMIT_FLAGS, rv);
            `CHK("lim clear", 16'h0000, rv)
        end
        // Each state source: entry with enable off is ignored
        for (int k = 0; k < 5; k++) begin
            st = 5'h10 >> k;
            repeat (3) @(negedge core_clk);
            rd_reg(cae_pkg::CODE_STATE_FLAGS, rv);
            `CHK("masked st", 16'h0000, rv)
            st = 5'h00;
            wr_reg(cae_pkg::CODE_STATE_EN, 16'h0001 << sbit[k]);
            st = 5'h10 >> k;
            wait_line(1'b0);
            rd_reg(cae_pkg::CODE_STATE_FLAGS, rv);
            `CHK("st flag", 16'h0001 << sbit[k], rv)
            st = 5'h00;
            wr_reg(cae_pkg::CODE_STATE_EN, 16'h0000);
            wait_line(1'b1);
            rd_reg(cae_pkg::CODE_STATE_FLAGS, rv);
            `CHK("st hidden", 16'h0001 << sbit[k], rv)
            wr_reg(cae_pkg::CODE_STATE_FLAGS, 16'h0000);
            rd_reg(cae_pkg::CODE_STATE_FLAGS, rv);
            `CHK("st clear", 16'h0000, rv)
        end
        // Set beats a clear taken on the same edge
        wr_reg(cae_pkg::CODE_LIMIT_EN, 16'h0001);
        limit_cond = 6'h01;
        wr_reg(cae_pkg::CODE_LIMIT_FLAGS, 16'h0000);
        limit_cond = 6'h00;
        rd_reg(cae_pkg::CODE_LIMIT_FLAGS, rv);
        `CHK("set wins", 16'h0001, rv)
        wr_reg(cae_pkg::CODE_STATE_EN, 16'h1fff);
        // Reset in mid-run empties enables and flags, releases the line
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK("rst line", 1'b1, alert_line)
        nrst = 1'b1;
        rd_reg(cae_pkg::CODE_LIMIT_FLAGS, rv);
        `CHK("rst flags", 16'h0000, rv)
        rd_reg(cae_pkg::CODE_LIMIT_EN, rv);
        `CHK("rst limit en", cae_pkg::LIMIT_EN_RST, rv)
        rd_reg(cae_pkg::CODE_STATE_EN, rv);
        `CHK("rst state en", 16'h0000, rv)
        `CHK("rst line idle", 1'b1, alert_line)
        close_out();
    end
endmodule
`undef CHK
`default_nettype wire
